// File: hw/split_autoreload_timer.sv
`timescale 1ns/1ps
`default_nettype none

module split_autoreload_timer (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Register bus
  input wire split_timer_pkg::sfr_req_s I_SFR,
  output logic [7:0] O_RDATA,
  // Processor-side enables and clock selects
  input wire logic I_TIMER_IRQ_ENABLE,
  input wire logic I_HIGH_BYTE_SYSTEM_CLOCK_SELECT,
  input wire logic I_LOW_BYTE_SYSTEM_CLOCK_SELECT,
  // External oscillator pin
  input wire logic I_EXT_OSC,
  // Interrupt request
  output logic O_IRQ
);

  // ************************************************************
  // State and decode
  // ************************************************************
  split_timer_pkg::state_s s_q;
  split_timer_pkg::state_s s_d;
  logic tick12;
  logic tick_ext;
  logic tick_alt;
  logic lo_tick;
  logic hi_tick;
  logic lo_wrap;
  logic hi_wrap;
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] ctrl_rd;

  // Prescaler ticks; the ext tick needs a rising edge at the second stage (ext_sync vs ext_prev) and ext_div at EXT_LAST
  assign tick12 = (s_q.pre12 == split_timer_pkg::PRE_LAST);
  assign tick_ext = s_q.ext_sync && !s_q.ext_prev
    && (s_q.ext_div == split_timer_pkg::EXT_LAST);
  assign tick_alt = s_q.ctrl.alt_clock_select ? tick_ext : tick12;

  // Low byte runs free in split mode, only with run bit otherwise
  assign lo_tick = (I_LOW_BYTE_SYSTEM_CLOCK_SELECT || tick_alt)
    && (s_q.ctrl.split_select || s_q.ctrl.run_control);
  assign hi_tick = s_q.ctrl.split_select ? (s_q.ctrl.run_control
    && (I_HIGH_BYTE_SYSTEM_CLOCK_SELECT || tick_alt))
    : (lo_tick && s_q.count_low_byte == split_timer_pkg::BYTE_ALL_ONES);
  assign lo_wrap = lo_tick
    && (s_q.count_low_byte == split_timer_pkg::BYTE_ALL_ONES);
  assign hi_wrap = hi_tick
    && (s_q.count_high_byte == split_timer_pkg::BYTE_ALL_ONES);

  assign wr_ctrl = I_SFR.wr && I_SFR.addr == split_timer_pkg::ADDR_TICK_CONTROL;
  assign wr_lo = I_SFR.wr && I_SFR.addr == split_timer_pkg::ADDR_COUNT_LOW;
  assign wr_hi = I_SFR.wr && I_SFR.addr == split_timer_pkg::ADDR_COUNT_HIGH;

  // Control readback; unused positions stay zero
  always_comb
  begin
    ctrl_rd = split_timer_pkg::BYTE_RESET;
    ctrl_rd[split_timer_pkg::BIT_HIGH_WRAP] = s_q.ctrl.high_wrap_flag;
    ctrl_rd[split_timer_pkg::BIT_LOW_WRAP] = s_q.ctrl.low_wrap_flag;
    ctrl_rd[split_timer_pkg::BIT_LOW_IRQ_EN] = s_q.ctrl.low_wrap_irq_enable;
    ctrl_rd[split_timer_pkg::BIT_SPLIT] = s_q.ctrl.split_select;
    ctrl_rd[split_timer_pkg::BIT_RUN] = s_q.ctrl.run_control;
    ctrl_rd[split_timer_pkg::BIT_ALT_CLK] = s_q.ctrl.alt_clock_select;
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    // Two-stage synchroniser, then edge count for divide by 8
    // Pin must toggle slower than I_CLK or rising edges are lost
    s_d.ext_meta = I_EXT_OSC;
    s_d.ext_sync = s_q.ext_meta;
    s_d.ext_prev = s_q.ext_sync;
    if (s_q.ext_sync && !s_q.ext_prev)
    begin
      s_d.ext_div = s_q.ext_div + 3'h1;
    end
    // Free-running divide by 12
    s_d.pre12 = tick12 ? split_timer_pkg::PRE_RESET : s_q.pre12 + 4'h1;

    // Counters: in 16-bit mode the reload happens only on full wrap
    if (lo_tick)
    begin
      if (lo_wrap && (s_q.ctrl.split_select || hi_wrap))
      begin
        s_d.count_low_byte = s_q.reload_low_byte;
      end
      else
      begin
        s_d.count_low_byte = s_q.count_low_byte + 8'h01;
      end
    end
    if (hi_tick)
    begin
      s_d.count_high_byte = hi_wrap ? s_q.reload_high_byte
        : s_q.count_high_byte + 8'h01;
    end

    // Software writes; flags may only be written, never self-cleared
    if (wr_ctrl)
    begin
      s_d.ctrl.high_wrap_flag = I_SFR.wdata[split_timer_pkg::BIT_HIGH_WRAP];
      s_d.ctrl.low_wrap_flag = I_SFR.wdata[split_timer_pkg::BIT_LOW_WRAP];
      s_d.ctrl.low_wrap_irq_enable =
        I_SFR.wdata[split_timer_pkg::BIT_LOW_IRQ_EN];
      s_d.ctrl.split_select = I_SFR.wdata[split_timer_pkg::BIT_SPLIT];
      s_d.ctrl.run_control = I_SFR.wdata[split_timer_pkg::BIT_RUN];
      s_d.ctrl.alt_clock_select = I_SFR.wdata[split_timer_pkg::BIT_ALT_CLK];
    end
    if (I_SFR.wr && I_SFR.addr == split_timer_pkg::ADDR_RELOAD_LOW)
    begin
      s_d.reload_low_byte = I_SFR.wdata;
    end
    if (I_SFR.wr && I_SFR.addr == split_timer_pkg::ADDR_RELOAD_HIGH)
    begin
      s_d.reload_high_byte = I_SFR.wdata;
    end
    // Software write to a count wins over a same-cycle tick
    if (wr_lo)
    begin
      s_d.count_low_byte = I_SFR.wdata;
    end
    if (wr_hi)
    begin
      s_d.count_high_byte = I_SFR.wdata;
    end

    // Hardware set applied last so it beats a same-cycle clear
    if (hi_wrap)
    begin
      s_d.ctrl.high_wrap_flag = 1'b1;
    end
    if (lo_wrap)
    begin
      s_d.ctrl.low_wrap_flag = 1'b1;
    end

    // Read data registered, unmapped addresses read zero
    if (I_SFR.rd)
    begin
      case (I_SFR.addr)
        split_timer_pkg::ADDR_TICK_CONTROL: s_d.rdata = ctrl_rd;
        split_timer_pkg::ADDR_RELOAD_LOW: s_d.rdata = s_q.reload_low_byte;
        split_timer_pkg::ADDR_RELOAD_HIGH: s_d.rdata = s_q.reload_high_byte;
        split_timer_pkg::ADDR_COUNT_LOW: s_d.rdata = s_q.count_low_byte;
        split_timer_pkg::ADDR_COUNT_HIGH: s_d.rdata = s_q.count_high_byte;
        default: s_d.rdata = split_timer_pkg::BYTE_RESET;
      endcase
    end

    // Level request, one cycle behind the flags it follows
    s_d.irq = I_TIMER_IRQ_ENABLE && (s_q.ctrl.high_wrap_flag
      || (s_q.ctrl.low_wrap_irq_enable && s_q.ctrl.low_wrap_flag));
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign O_RDATA = s_q.rdata;
  assign O_IRQ = s_q.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence full_wrap16;
    !s_q.ctrl.split_select && lo_tick && hi_wrap && !wr_lo && !wr_hi;
  endsequence

  sequence reloaded16;
    s_q.count_low_byte == $past(s_q.reload_low_byte)
      && s_q.count_high_byte == $past(s_q.reload_high_byte)
      && s_q.ctrl.high_wrap_flag;
  endsequence

  sequence flag_raised;
    I_TIMER_IRQ_ENABLE && s_q.ctrl.high_wrap_flag;
  endsequence

  sequence low_wrap_split;
    s_q.ctrl.split_select && lo_wrap && !wr_lo;
  endsequence

  sequence low_reloaded;
    s_q.count_low_byte == $past(s_q.reload_low_byte)
      && s_q.ctrl.low_wrap_flag;
  endsequence

  AST_WRAP16_RELOAD: assert property (
    full_wrap16 |=> reloaded16)
    else $error("16-bit wrap did not reload or flag");

  AST_STOP16: assert property (
    !s_q.ctrl.split_select && !s_q.ctrl.run_control && !wr_lo && !wr_hi
    |=> $stable(s_q.count_low_byte) && $stable(s_q.count_high_byte))
    else $error("stopped 16-bit timer moved");

  AST_SPLIT_LOW_FREE: assert property (
    s_q.ctrl.split_select && I_LOW_BYTE_SYSTEM_CLOCK_SELECT && !wr_lo
    && s_q.count_low_byte != split_timer_pkg::BYTE_ALL_ONES
    |=> s_q.count_low_byte == $past(s_q.count_low_byte) + 8'h01)
    else $error("split low byte did not count on system clock");

  AST_SPLIT_HIGH_STOP: assert property (
    s_q.ctrl.split_select && !s_q.ctrl.run_control && !wr_hi
    |=> $stable(s_q.count_high_byte))
    else $error("split high byte counted while stopped");

  AST_SPLIT_HIGH_WRAP: assert property (
    s_q.ctrl.split_select && hi_wrap && !wr_hi
    |=> s_q.count_high_byte == $past(s_q.reload_high_byte)
      && s_q.ctrl.high_wrap_flag)
    else $error("split high wrap did not reload or flag");

  // Eleven quiet cycles between two prescaler ticks
  AST_DIV12: assert property (
    tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
    else $error("divide by 12 tick spacing wrong");

  AST_LOW_FLAG: assert property (
    lo_wrap |=> s_q.ctrl.low_wrap_flag)
    else $error("low wrap did not set low flag");

  AST_STICKY: assert property (
    s_q.ctrl.high_wrap_flag && !wr_ctrl |=> s_q.ctrl.high_wrap_flag)
    else $error("high flag cleared without a write");

  AST_SET_WINS: assert property (
    wr_ctrl && !I_SFR.wdata[split_timer_pkg::BIT_LOW_WRAP] && lo_wrap
    |=> s_q.ctrl.low_wrap_flag)
    else $error("software clear beat hardware set");

  AST_UNUSED_ZERO: assert property (
    I_SFR.rd && I_SFR.addr == split_timer_pkg::ADDR_TICK_CONTROL
    |=> !O_RDATA[4] && !O_RDATA[1])
    else $error("unused control bits read nonzero");

  // Request follows an enabled high flag one cycle later
  AST_IRQ_HIGH: assert property (
    flag_raised |=> O_IRQ)
    else $error("interrupt missing for high flag");

  AST_IRQ_LOW: assert property (
    I_TIMER_IRQ_ENABLE && s_q.ctrl.low_wrap_irq_enable
    && s_q.ctrl.low_wrap_flag |=> O_IRQ)
    else $error("interrupt missing for low flag");

  AST_IRQ_DROP: assert property (
    !I_TIMER_IRQ_ENABLE |=> !O_IRQ)
    else $error("interrupt stayed up with enable clear");

  // Split low byte refills from its own reload byte
  AST_SPLIT_LOW_RELOAD: assert property (
    low_wrap_split |=> low_reloaded)
    else $error("split low wrap did not reload or flag");

  // Low flag is as sticky as the high one
  AST_LOW_STICKY: assert property (
    s_q.ctrl.low_wrap_flag && !wr_ctrl |=> s_q.ctrl.low_wrap_flag)
    else $error("low flag cleared without a write");

  // No enabled flag means no request one cycle later
  AST_IRQ_QUIET: assert property (
    !s_q.ctrl.high_wrap_flag
    && !(s_q.ctrl.low_wrap_irq_enable && s_q.ctrl.low_wrap_flag)
    |=> !O_IRQ)
    else $error("interrupt raised with no enabled flag");

  // Read data only changes on a read strobe
  AST_RDATA_HOLD: assert property (
    !I_SFR.rd |=> $stable(O_RDATA))
    else $error("read data moved without a read");

  // Split high byte on system clock with the run bit set advances every cycle
  AST_SPLIT_HIGH_RUN: assert property (
    s_q.ctrl.split_select && s_q.ctrl.run_control
    && I_HIGH_BYTE_SYSTEM_CLOCK_SELECT && !wr_hi
    && s_q.count_high_byte != split_timer_pkg::BYTE_ALL_ONES
    |=> s_q.count_high_byte == $past(s_q.count_high_byte) + 8'h01)
    else $error("split high byte did not count on system clock");

  // Eight synchronised edges never fit in eight cycles
  AST_EXT_SPACING: assert property (
    tick_ext |=> !tick_ext [*8])
    else $error("ext divide by 8 tick came too soon");

  // Split low byte off system clock moves only on the chosen tick
  AST_SPLIT_LOW_ALT: assert property (
    s_q.ctrl.split_select && !I_LOW_BYTE_SYSTEM_CLOCK_SELECT && !wr_lo
    && !(s_q.ctrl.alt_clock_select ? tick_ext : tick12)
    |=> $stable(s_q.count_low_byte))
    else $error("split low byte moved without its tick");

  // 16-bit mode carries a low wrap into the high byte
  AST_CARRY16: assert property (
    !s_q.ctrl.split_select && lo_wrap && !hi_wrap && !wr_lo && !wr_hi
    |=> s_q.count_low_byte == split_timer_pkg::BYTE_RESET
      && s_q.count_high_byte == $past(s_q.count_high_byte) + 8'h01)
    else $error("16-bit low wrap did not carry");

endmodule // split_autoreload_timer

`default_nettype wire

// File: common/split_timer_pkg.sv
`default_nettype none

package split_timer_pkg;

  // ************************************************************
  // Register addresses on the special-function-register bus
  // ************************************************************
  localparam logic [7:0] ADDR_TICK_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;

  // ************************************************************
  // Control register field positions and reset values
  // ************************************************************
  localparam int BIT_HIGH_WRAP = 7;
  localparam int BIT_LOW_WRAP = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_ALT_CLK = 0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hff;

  // ************************************************************
  // Prescaler constants
  // ************************************************************
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;
  localparam logic [3:0] PRE_LAST = 4'(SYS_DIV - 1);
  localparam logic [3:0] PRE_RESET = 4'h0;
  localparam logic [2:0] EXT_LAST = 3'(EXT_DIV - 1);
  localparam logic [2:0] EXT_RESET = 3'h0;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic high_wrap_flag;
    logic low_wrap_flag;
    logic low_wrap_irq_enable;
    logic split_select;
    logic run_control;
    logic alt_clock_select;
  } ctrl_s;

  typedef struct packed {
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic [2:0] ext_div;
    logic [3:0] pre12;
    ctrl_s ctrl;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] rdata;
    logic irq;
  } state_s;

endpackage

`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ****************
  // Bench signals
  // ****************
  localparam logic [7:0] a_ctl = split_timer_pkg::ADDR_TICK_CONTROL;
  localparam logic [7:0] a_rll = split_timer_pkg::ADDR_RELOAD_LOW;
  localparam logic [7:0] a_rlh = split_timer_pkg::ADDR_RELOAD_HIGH;
  localparam logic [7:0] a_cnl = split_timer_pkg::ADDR_COUNT_LOW;
  localparam logic [7:0] a_cnh = split_timer_pkg::ADDR_COUNT_HIGH;
  localparam logic [7:0] addrs [6] = '{a_ctl, a_rll, a_rlh, a_cnl, a_cnh,
    8'hc9};
  // Low enable only with split on, as software must
  localparam logic [7:0] irq_cases [4] = '{8'h04, 8'h29, 8'h08, 8'h28};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  split_timer_pkg::sfr_req_s sfr = '0;
  logic [7:0] rdata;
  logic tmr_ie = 1'b1;
  logic hi_sel = 1'b1;
  logic lo_sel = 1'b1;
  logic ext_osc = 1'b0;
  logic ext_en = 1'b0;
  logic [1:0] ext_cnt = 2'h0;
  logic irq;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 32'hf123;
  // Register image of the bench, keyed by address
  logic [7:0] model [logic [7:0]];

  split_autoreload_timer split_autoreload_timer_i (
    .I_CLK(clk),
    .I_RST_N(rst_n),
    .I_SFR(sfr),
    .O_RDATA(rdata),
    .I_TIMER_IRQ_ENABLE(tmr_ie),
    .I_HIGH_BYTE_SYSTEM_CLOCK_SELECT(hi_sel),
    .I_LOW_BYTE_SYSTEM_CLOCK_SELECT(lo_sel),
    .I_EXT_OSC(ext_osc),
    .O_IRQ(irq)
  );

  // 250 MHz system clock
  always #2 clk = ~clk;

  // Oscillator at a quarter of the system clock, slow enough to sync
  always @(posedge clk)
  begin
    if (ext_en)
    begin
      ext_cnt <= ext_cnt + 2'h1;
      if (ext_cnt[0])
        ext_osc <= ~ext_osc;
    end
  end

  // ****************
  // Bus and checks
  // ****************
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Range test, for counts whose start phase is free running
  task automatic in_range(input string what, input logic [7:0] v,
                          input logic [7:0] lo, input logic [7:0] hi);
    check(what, 8'(v >= lo && v <= hi), 8'h01);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr.wr <= 1'b1;
    sfr.addr <= a;
    sfr.wdata <= d;
    @(posedge clk);
    sfr.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr.rd <= 1'b1;
    sfr.addr <= a;
    @(posedge clk);
    sfr.rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    logic [7:0] d;
    logic [7:0] v;
    logic got;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, unmapped place included
    for (int k = 0; k < 6; k++)
    begin
      rd(addrs[k], d);
      check("reset value", d, 8'h00);
    end
    // Random data through every byte but control; unmapped write must not stick
    for (int k = 1; k < 6; k++)
    begin
      v = 8'($random(seed));
      model[addrs[k]] = (addrs[k] == 8'hc9) ? 8'h00 : v;
      wr(addrs[k], v);
      rd(addrs[k], d);
      check("byte readback", d, model[addrs[k]]);
    end
    // Unused control bits, then every field with no clock running
    wr(a_ctl, 8'h12);
    rd(a_ctl, d);
    check("unused bits", d, 8'h00);
    lo_sel <= 1'b0;
    hi_sel <= 1'b0;
    wr(a_ctl, 8'hed);
    rd(a_ctl, d);
    check("control fields", d, 8'hed);
    check("irq level", {7'h0, irq}, 8'h01);
    // Processor enable gates the request while flags stay set
    tmr_ie <= 1'b0;
    repeat (3) @(posedge clk);
    check("irq gated", {7'h0, irq}, 8'h00);
    tmr_ie <= 1'b1;
    repeat (3) @(posedge clk);
    check("irq back", {7'h0, irq}, 8'h01);
    wr(a_ctl, 8'h00);
    repeat (3) @(posedge clk);
    check("irq drop", {7'h0, irq}, 8'h00);
    lo_sel <= 1'b1;
    hi_sel <= 1'b1;
    // Low wrap flag and interrupt in each mode and enable
    for (int k = 0; k < 4; k++)
    begin
      wr(a_ctl, 8'h00);
      wr(a_cnl, 8'hf8);
      wr(a_cnh, 8'h10);
      wr(a_ctl, irq_cases[k]);
      got = 1'b0;
      repeat (24)
      begin
        @(posedge clk);
        if (irq === 1'b1)
          got = 1'b1;
      end
      check("wrap irq", {7'h0, got}, {7'h0, irq_cases[k][5]});
      rd(a_ctl, d);
      check("low flag", d, irq_cases[k] | 8'h40);
      rd(a_cnh, d);
      check("high byte", d, irq_cases[k][3] ? 8'h10 : 8'h11);
    end
    // Clear of the low flag in its wrap cycle loses to the set
    wr(a_ctl, 8'h08);
    wr(a_cnl, 8'hfe);
    wr(a_ctl, 8'h08);
    rd(a_ctl, d);
    check("set wins", d, 8'h48);
    // Full wrap reloads, 16-bit then split
    for (int k = 0; k < 2; k++)
    begin
      wr(a_ctl, 8'h00);
      wr(a_rll, 8'h40);
      wr(a_rlh, 8'h80);
      wr(a_cnl, 8'hfc);
      wr(a_cnh, 8'hff);
      wr(a_ctl, (k == 1) ? 8'h0c : 8'h04);
      repeat (12) @(posedge clk);
      rd(a_ctl, d);
      check("high flag", {7'h0, d[7]}, 8'h01);
      rd(a_cnh, d);
      in_range("high reload", d, 8'h80, (k == 1) ? 8'h9f : 8'h80);
      rd(a_cnl, d);
      in_range("low reload", d, 8'h40, 8'h5f);
    end
    // Clock sources: system clock, divide by 12, oscillator over 8
    for (int k = 0; k < 3; k++)
    begin
      wr(a_ctl, 8'h00);
      wr(a_cnl, 8'h00);
      wr(a_cnh, 8'h00);
      lo_sel <= (k == 0);
      ext_en <= (k == 2);
      wr(a_ctl, (k == 2) ? 8'h05 : 8'h04);
      repeat ((k == 0) ? 20 : 124) @(posedge clk);
      wr(a_ctl, (k == 2) ? 8'h01 : 8'h00);
      ext_en <= 1'b0;
      repeat (8) @(posedge clk);
      rd(a_cnl, d);
      case (k)
        0: in_range("system_clock count", d, 8'd19, 8'd23);
        1: in_range("div12 count", d, 8'd9, 8'd11);
        default: in_range("ext count", d, 8'd3, 8'd5);
      endcase
    end
    // Reset with the timer stopped brings every byte back to zero
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      rd(addrs[k], d);
      check("second reset", d, 8'h00);
    end
    check("irq after reset", {7'h0, irq}, 8'h00);
    end_sim();
  end
endmodule // testbench

`default_nettype wire
